//--- shared/srp_regs.svh
`ifndef SRP_REGS_SVH
`define SRP_REGS_SVH
`define SRP_ADDR_CFG      12'h000
`define SRP_ADDR_TERMV    12'h004
`define SRP_ADDR_FSSOC    12'h008
`define SRP_ADDR_RES      12'h00C
`define SRP_ADDR_IMAX_CFG 12'h010
`define SRP_ADDR_RESERVE  12'h014
`define SRP_ADDR_TDD_PCT  12'h018
`define SRP_ADDR_IRQ_STAT 12'h01C
`define SRP_ADDR_IRQ_MASK 12'h020
`define SRP_ADDR_REPORT   12'h024
`define SRP_ADDR_PEAK     12'h028
`define SRP_ADDR_STATUS   12'h02C
`define SRP_ADDR_RMEAS    12'h030
`define SRP_CFG_RST       32'h0000_0000
`define SRP_TERMV_RST     16'h0BB8
`define SRP_FSSOC_RST     8'h0A
`define SRP_TDD_PCT_RST   8'h50
`define SRP_SCALE_TIME_S  30
`define SRP_SCALE_TICKS   ((`SRP_SCALE_TIME_S * 1000) / 1000)
`define SRP_B_SMOOTH      0
`define SRP_B_RLXSM       1
`define SRP_B_SYNC        2
`define SRP_B_HOLDOC      3
`define SRP_B_HOLDOD      4
`define SRP_B_H99         5
`define SRP_B_H1          6
`define SRP_B_PEAK_CURRENT_ENABLE      7
`define SRP_B_RESVEN      8
`define SRP_B_INTERRUPT_POLARITY      9
`define SRP_B_TRIPEN      10
`define SRP_B_TDDEN       11
`define SRP_B_FSTHERM     12
`define SRP_B_LDSEL       16
`define SRP_B_FSLDSEL     20
`endif

//--- shared/srp_pkg.sv
package srp_pkg;
    typedef enum logic [1:0] {
        SRP_PM_SHUT = 2'b00,
        SRP_PM_LVC  = 2'b01,
        SRP_PM_NORM = 2'b10
    } srp_pmode_t;
    typedef logic [15:0] srp_cap_t;
endpackage : srp_pkg

//--- src/srp_peak_calc.sv
`timescale 1ns/1ps
`include "srp_regs.svh"
module srp_peak_calc
    import srp_pkg::*;
(
    input  wire logic        mclk_i,
    input  wire logic        sys_rst_i,
    input  wire logic        ce_i,
    input  wire logic        upd_i,
    input  wire logic        en_i,
    input  wire logic        resv_en_i,
    input  wire logic [15:0] allowed_i,
    input  wire logic [7:0]  pulse_i,
    input  wire logic [15:0] reserve_i,
    input  wire logic [15:0] remain_i,
    input  wire logic [15:0] step_i,
    output logic      [15:0] peak_o,
    output logic             chg_o
);
    logic [15:0] avail;
    logic [15:0] calc;
    logic [15:0] diff;
    logic [23:0] lim;

    // Reserve capacity is withheld from the usable charge when enabled
    always_comb begin
        avail = (resv_en_i && remain_i > reserve_i) ? remain_i - reserve_i :
                (resv_en_i ? 16'h0000 : remain_i);
        lim   = {8'h00, avail} / {16'h0000, (pulse_i == 8'h00) ? 8'h01 : pulse_i};
        calc  = (lim[23:16] != 8'h00 || lim[15:0] > allowed_i) ? allowed_i : lim[15:0];
        diff  = (calc > peak_o) ? calc - peak_o : peak_o - calc;
    end

    // Peak figure refreshes on each gauge update; pulse when step exceeded
    always_ff @(posedge mclk_i) begin
        if (sys_rst_i) begin
            peak_o <= 16'h0000;
            chg_o  <= 1'b0;
        end else if (ce_i) begin
            chg_o <= 1'b0;
            if (upd_i && en_i) begin
                peak_o <= calc;
                chg_o  <= diff > step_i;
            end
        end
    end
endmodule : srp_peak_calc

//--- src/srp_top.sv
`timescale 1ns/1ps
`include "srp_regs.svh"
module srp_top
    import srp_pkg::*;
(
    input  wire logic        mclk_i,
    input  wire logic        sys_rst_i,
    input  wire logic        ce_i,
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [11:0] paddr,
    input  wire logic [31:0] pwdata,
    output logic      [31:0] prdata,
    output logic             pready,
    output logic             pslverr,
    input  wire logic        tick_i,
    input  wire logic        charging_i,
    input  wire logic        discharging_i,
    input  wire logic        relax_i,
    input  wire logic [15:0] true_rm_i,
    input  wire logic [15:0] true_fcc_i,
    input  wire logic [15:0] volt_i,
    input  wire logic [15:0] cell_res_i,
    input  wire logic [15:0] meas_res_i,
    input  wire logic        meas_vld_i,
    input  wire logic        full_term_i,
    input  wire logic [7:0]  soh_i,
    input  wire logic        ov_det_i,
    input  wire logic        uv_det_i,
    input  wire logic        otc_det_i,
    input  wire logic        otd_det_i,
    input  wire logic        isd_det_i,
    input  wire logic        chg_conn_i,
    input  wire logic        below_por_i,
    input  wire logic        fault_i,
    output logic             irq_o,
    output logic             host_int_o,
    output logic             fast_scale_o,
    output logic             scale_pulse_o,
    output logic [3:0]       load_sel_o,
    output logic             therm_en_o,
    output logic [15:0]      sim_res_o,
    output logic [15:0]      stored_res_o,
    output logic [1:0]       pmode_o
);
    logic [31:0] cfg;
    logic [15:0] term_v;
    logic [15:0] term_dv;
    logic [7:0]  fs_soc;
    logic [15:0] trace_r;
    logic [15:0] down_r;
    logic [15:0] allowed;
    logic [7:0]  pulse;
    logic [15:0] step;
    logic [15:0] reserve;
    logic [7:0]  tdd_pct;
    logic [7:0]  irq_stat;
    logic [7:0]  irq_mask;
    logic [15:0] filt_rm;
    logic [15:0] filt_fcc;
    logic [15:0] rep_rm;
    logic [15:0] rep_fcc;
    logic [7:0]  rep_soc;
    logic [7:0]  prev_soh;
    logic        full_charge_flag;
    logic        tab_disconnect_flag;
    logic [5:0]  safety;
    logic [4:0]  scale_cnt;
    logic [15:0] peak_current_value;
    logic        peak_chg;
    srp_pmode_t  pmode;
    logic        wr;
    logic        rd;
    logic [7:0]  raw_soc;
    logic [7:0]  next_soc;
    logic        fast_cond;
    logic        tdd_hit;
    logic [7:0]  ev;

    // Percent of remaining over full, saturated at 100
    function automatic logic [7:0] pct(input logic [15:0] rm, input logic [15:0] fcc);
        logic [23:0] q;
        q = 24'h000000;
        if (fcc != 16'h0000) begin
            q = ({8'h00, rm} * 24'h000064) / {8'h00, fcc};
        end
        pct = (q > 24'h000064) ? 8'h64 : q[7:0];
    endfunction : pct

    // Saturating step of a value toward a target by one unit
    function automatic logic [15:0] toward(input logic [15:0] v, input logic [15:0] t);
        toward = (v < t) ? v + 16'h0001 : ((v > t) ? v - 16'h0001 : v);
    endfunction : toward

    assign wr = psel && penable && pwrite;
    assign rd = psel && penable && !pwrite;

    // Zero-wait slave; errors on addresses above the last register (SRP_ADDR_RMEAS)
    always_ff @(posedge mclk_i) begin
        if (sys_rst_i) begin
            pready  <= 1'b0;
            pslverr <= 1'b0;
        end else if (ce_i) begin
            pready  <= psel && !penable;
            pslverr <= psel && !penable && paddr > `SRP_ADDR_RMEAS;
        end
    end

    // Configuration writes
    always_ff @(posedge mclk_i) begin
        if (sys_rst_i) begin
            cfg      <= `SRP_CFG_RST;
            term_v   <= `SRP_TERMV_RST;
            term_dv  <= 16'h0064;
            fs_soc   <= `SRP_FSSOC_RST;
            trace_r  <= 16'h0000;
            down_r   <= 16'h0000;
            allowed  <= 16'h0000;
            pulse    <= 8'h01;
            step     <= 16'h0000;
            reserve  <= 16'h0000;
            tdd_pct  <= `SRP_TDD_PCT_RST;
            irq_mask <= 8'h00;
        end else if (ce_i && wr && pready) begin
            case (paddr)
                `SRP_ADDR_CFG:      cfg <= pwdata;
                `SRP_ADDR_TERMV: begin
                    term_v  <= pwdata[15:0];
                    term_dv <= pwdata[31:16];
                end
                `SRP_ADDR_FSSOC:    fs_soc <= pwdata[7:0];
                `SRP_ADDR_RES: begin
                    trace_r <= pwdata[15:0];
                    down_r  <= pwdata[31:16];
                end
                `SRP_ADDR_IMAX_CFG: begin
                    allowed <= pwdata[15:0];
                    pulse   <= pwdata[23:16];
                end
                `SRP_ADDR_RESERVE: begin
                    reserve <= pwdata[15:0];
                    step    <= pwdata[31:16];
                end
                `SRP_ADDR_TDD_PCT:  tdd_pct <= pwdata[7:0];
                `SRP_ADDR_IRQ_MASK: irq_mask <= pwdata[7:0];
                default: begin
                end
            endcase
        end
    end

    // Read mux; interrupt status register clears on read
    always_ff @(posedge mclk_i) begin
        if (sys_rst_i) begin
            prdata <= 32'h0000_0000;
        end else if (ce_i && psel && !penable) begin
            case (paddr)
                `SRP_ADDR_CFG:      prdata <= cfg;
                `SRP_ADDR_TERMV:    prdata <= {term_dv, term_v};
                `SRP_ADDR_FSSOC:    prdata <= {24'h000000, fs_soc};
                `SRP_ADDR_RES:      prdata <= {down_r, trace_r};
                `SRP_ADDR_IMAX_CFG: prdata <= {8'h00, pulse, allowed};
                `SRP_ADDR_RESERVE:  prdata <= {step, reserve};
                `SRP_ADDR_TDD_PCT:  prdata <= {24'h000000, tdd_pct};
                `SRP_ADDR_IRQ_STAT: prdata <= {24'h000000, irq_stat};
                `SRP_ADDR_IRQ_MASK: prdata <= {24'h000000, irq_mask};
                `SRP_ADDR_REPORT:   prdata <= {rep_fcc, rep_rm};
                `SRP_ADDR_PEAK:     prdata <= {8'h00, rep_soc, peak_current_value};
                `SRP_ADDR_STATUS:   prdata <= {22'h000000, pmode, full_charge_flag, tab_disconnect_flag, safety};
                `SRP_ADDR_RMEAS:    prdata <= {16'h0000, stored_res_o};
                default:            prdata <= 32'h0000_0000;
            endcase
        end
    end

    // Fast scaling region and 30-tick rescale cadence
    assign fast_cond = ({8'h00, rep_soc} <= {8'h00, fs_soc}) ||
                       ({1'b0, volt_i} < {1'b0, term_v} + {1'b0, term_dv});
    always_ff @(posedge mclk_i) begin
        if (sys_rst_i) begin
            fast_scale_o  <= 1'b0;
            scale_cnt     <= 5'h00;
            scale_pulse_o <= 1'b0;
            load_sel_o    <= 4'h0;
            therm_en_o    <= 1'b0;
        end else if (ce_i) begin
            scale_pulse_o <= 1'b0;
            if (tick_i) begin
                fast_scale_o <= fast_cond && discharging_i;
                if (!(fast_cond && discharging_i) || scale_cnt == 5'(`SRP_SCALE_TICKS - 1)) begin
                    scale_cnt     <= 5'h00;
                    scale_pulse_o <= fast_cond && discharging_i;
                end else begin
                    scale_cnt <= scale_cnt + 5'h01;
                end
            end
            load_sel_o <= fast_scale_o ? cfg[`SRP_B_FSLDSEL +: 4] : cfg[`SRP_B_LDSEL +: 4];
            therm_en_o <= !fast_scale_o || cfg[`SRP_B_FSTHERM];
        end
    end

    // Resistance compensation toward simulation and storage
    always_ff @(posedge mclk_i) begin
        if (sys_rst_i) begin
            sim_res_o    <= 16'h0000;
            stored_res_o <= 16'h0000;
        end else if (ce_i) begin
            sim_res_o <= cell_res_i + trace_r + down_r;
            if (meas_vld_i && discharging_i) begin
                stored_res_o <= (meas_res_i > trace_r) ? meas_res_i - trace_r : 16'h0000;
            end
        end
    end

    // Filtered capacity tracking: discharge delta, charge FCC, relax sync, holds
    always_ff @(posedge mclk_i) begin
        if (sys_rst_i) begin
            filt_rm  <= 16'h0000;
            filt_fcc <= 16'h0000;
        end else if (ce_i && tick_i) begin
            if (discharging_i) begin
                if (cfg[`SRP_B_HOLDOD] && filt_rm == 16'h0000 && true_rm_i == 16'h0000) begin
                    filt_rm <= filt_rm;
                end else if (cfg[`SRP_B_HOLDOC] && filt_rm >= filt_fcc && true_rm_i > filt_fcc) begin
                    filt_rm <= filt_rm;
                end else begin
                    filt_rm <= toward(filt_rm > 16'h0000 ? filt_rm - 16'h0001 : filt_rm, true_rm_i);
                end
            end else if (charging_i) begin
                if (cfg[`SRP_B_HOLDOC] && filt_rm >= filt_fcc && filt_fcc != 16'h0000) begin
                    filt_rm <= filt_rm;
                end else begin
                    filt_rm <= true_rm_i;
                end
                filt_fcc <= toward(filt_fcc, true_fcc_i + (filt_rm - true_rm_i));
            end else if (relax_i && cfg[`SRP_B_RLXSM]) begin
                filt_rm  <= cfg[`SRP_B_SYNC] ? true_rm_i : toward(filt_rm, true_rm_i);
                filt_fcc <= cfg[`SRP_B_SYNC] ? true_fcc_i : toward(filt_fcc, true_fcc_i);
            end
        end
    end

    // Reported values with 99/1 percent holds
    assign raw_soc = cfg[`SRP_B_SMOOTH] ? pct(filt_rm, filt_fcc) : pct(true_rm_i, true_fcc_i);
    always_comb begin
        next_soc = raw_soc;
        if (cfg[`SRP_B_H99] && raw_soc == 8'h64 && !full_charge_flag) begin
            next_soc = 8'h63;
        end
        if (cfg[`SRP_B_H1] && raw_soc == 8'h00 && volt_i > term_v) begin
            next_soc = 8'h01;
        end
    end
    always_ff @(posedge mclk_i) begin
        if (sys_rst_i) begin
            rep_rm  <= 16'h0000;
            rep_fcc <= 16'h0000;
            rep_soc <= 8'h00;
        end else if (ce_i) begin
            rep_rm  <= cfg[`SRP_B_SMOOTH] ? filt_rm : true_rm_i;
            rep_fcc <= cfg[`SRP_B_SMOOTH] ? filt_fcc : true_fcc_i;
            rep_soc <= next_soc;
        end
    end

    // Full charge flag follows termination, cleared on discharge
    always_ff @(posedge mclk_i) begin
        if (sys_rst_i) begin
            full_charge_flag <= 1'b0;
        end else if (ce_i) begin
            if (full_term_i) begin
                full_charge_flag <= 1'b1;
            end else if (discharging_i) begin
                full_charge_flag <= 1'b0;
            end
        end
    end

    srp_peak_calc u_peak (
        .mclk_i    (mclk_i),
        .sys_rst_i (sys_rst_i),
        .ce_i      (ce_i),
        .upd_i     (tick_i),
        .en_i      (cfg[`SRP_B_PEAK_CURRENT_ENABLE]),
        .resv_en_i (cfg[`SRP_B_RESVEN]),
        .allowed_i (allowed),
        .pulse_i   (pulse),
        .reserve_i (reserve),
        .remain_i  (rep_rm),
        .step_i    (step),
        .peak_o    (peak_current_value),
        .chg_o     (peak_chg)
    );

    // Tab disconnect: health ratio below percent, checked per update
    assign tdd_hit = cfg[`SRP_B_TDDEN] && tick_i && prev_soh != 8'h00 &&
                     ({8'h00, soh_i} * 16'h0064) < ({8'h00, prev_soh} * {8'h00, tdd_pct});
    always_ff @(posedge mclk_i) begin
        if (sys_rst_i) begin
            prev_soh <= 8'h00;
        end else if (ce_i && tick_i) begin
            prev_soh <= soh_i;
        end
    end

    // Safety flags are sticky notification bits
    always_ff @(posedge mclk_i) begin
        if (sys_rst_i) begin
            safety              <= 6'h00;
            tab_disconnect_flag <= 1'b0;
        end else if (ce_i) begin
            safety <= safety | {tdd_hit, isd_det_i, otd_det_i, otc_det_i, uv_det_i, ov_det_i};
            if (tdd_hit) begin
                tab_disconnect_flag <= 1'b1;
            end
        end
    end

    // Interrupt status: set beats clear-on-read
    assign ev = {1'b0, peak_chg, tdd_hit, isd_det_i, otd_det_i, otc_det_i, uv_det_i, ov_det_i};
    always_ff @(posedge mclk_i) begin
        if (sys_rst_i) begin
            irq_stat <= 8'h00;
        end else if (ce_i) begin
            if (rd && pready && paddr == `SRP_ADDR_IRQ_STAT) begin
                // Only bits already shown in prdata clear; later events survive the read
                irq_stat <= (irq_stat & ~prdata[7:0]) | ev;
            end else begin
                irq_stat <= irq_stat | ev;
            end
        end
    end

    // Interrupt outputs; host pin takes the four masked events in bits 5:2 with polarity set and trip off, plus peak-change bit 6 when peak current is enabled
    always_ff @(posedge mclk_i) begin
        if (sys_rst_i) begin
            irq_o      <= 1'b0;
            host_int_o <= 1'b0;
        end else if (ce_i) begin
            irq_o      <= |(irq_stat & irq_mask);
            host_int_o <= cfg[`SRP_B_INTERRUPT_POLARITY] && !cfg[`SRP_B_TRIPEN] &&
                          |(irq_stat[5:2] & irq_mask[5:2]) || (cfg[`SRP_B_PEAK_CURRENT_ENABLE] && irq_stat[6]);
        end
    end

    // Power mode on exit from analog shutdown
    always_ff @(posedge mclk_i) begin
        if (sys_rst_i) begin
            pmode <= SRP_PM_SHUT;
        end else if (ce_i) begin
            case (pmode)
                SRP_PM_SHUT: begin
                    if (chg_conn_i && below_por_i) begin
                        pmode <= SRP_PM_LVC;
                    end else if (chg_conn_i && !fault_i) begin
                        pmode <= SRP_PM_NORM;
                    end
                end
                SRP_PM_LVC: begin
                    if (!below_por_i && !fault_i) begin
                        pmode <= SRP_PM_NORM;
                    end
                end
                default: pmode <= pmode;
            endcase
        end
    end
    assign pmode_o = pmode;

    // Checks
    property p_hold99;
        @(posedge mclk_i) disable iff (sys_rst_i)
        ce_i && cfg[`SRP_B_H99] && !full_charge_flag && raw_soc == 8'h64 |=> rep_soc == 8'h63;
    endproperty
    a_hold99: assert property (p_hold99) else $error("soc reached 100 without full flag");
    property p_sel;
        @(posedge mclk_i) disable iff (sys_rst_i)
        ce_i && !cfg[`SRP_B_SMOOTH] |=> rep_rm == $past(true_rm_i);
    endproperty
    a_sel: assert property (p_sel) else $error("unfiltered remaining not reported");
    property p_trace;
        @(posedge mclk_i) disable iff (sys_rst_i)
        ce_i && meas_vld_i && discharging_i && meas_res_i > trace_r |=> stored_res_o == $past(meas_res_i) - $past(trace_r);
    endproperty
    a_trace: assert property (p_trace) else $error("trace not removed");
    property p_sim;
        @(posedge mclk_i) disable iff (sys_rst_i)
        ce_i |=> sim_res_o == $past(cell_res_i) + $past(trace_r) + $past(down_r);
    endproperty
    a_sim: assert property (p_sim) else $error("simulation resistance wrong");
    property p_therm;
        @(posedge mclk_i) disable iff (sys_rst_i)
        ce_i && fast_scale_o && !cfg[`SRP_B_FSTHERM] |=> !therm_en_o;
    endproperty
    a_therm: assert property (p_therm) else $error("thermal on in fast region");
    property p_ld;
        @(posedge mclk_i) disable iff (sys_rst_i)
        ce_i && fast_scale_o |=> load_sel_o == $past(cfg[`SRP_B_FSLDSEL +: 4]);
    endproperty
    a_ld: assert property (p_ld) else $error("fast load select unused");
    property p_host;
        @(posedge mclk_i) disable iff (sys_rst_i)
        ce_i && cfg[`SRP_B_TRIPEN] && !cfg[`SRP_B_PEAK_CURRENT_ENABLE] |=> !host_int_o;
    endproperty
    a_host: assert property (p_host) else $error("host interrupt while trip enabled");
    property p_lvc;
        @(posedge mclk_i) disable iff (sys_rst_i)
        ce_i && pmode == SRP_PM_SHUT && chg_conn_i && below_por_i |=> pmode == SRP_PM_LVC;
    endproperty
    a_lvc: assert property (p_lvc) else $error("no low voltage charge entry");
    property p_tdd;
        @(posedge mclk_i) disable iff (sys_rst_i)
        ce_i && tdd_hit |=> tab_disconnect_flag && safety[5];
    endproperty
    a_tdd: assert property (p_tdd) else $error("tab disconnect flag missed");
    c_fast: cover property (@(posedge mclk_i) disable iff (sys_rst_i) scale_pulse_o);
    c_norm: cover property (@(posedge mclk_i) disable iff (sys_rst_i) pmode == SRP_PM_NORM);
    c_irq:  cover property (@(posedge mclk_i) disable iff (sys_rst_i) irq_o);
endmodule : srp_top

//--- bench/srp_host_model.sv
`timescale 1ns/1ps
// Host processor on the far side of the register bus; one APB transfer at a time
module srp_host_model (
    input  wire logic        mclk_i,
    output logic             psel = 1'b0,
    output logic             penable = 1'b0,
    output logic             pwrite = 1'b0,
    output logic      [11:0] paddr = 12'h000,
    output logic      [31:0] pwdata = 32'h0000_0000,
    input  wire logic [31:0] prdata,
    input  wire logic        pready,
    input  wire logic        pslverr
);
    logic [31:0] rd;
    logic        err;
    logic        tmo;

    // Setup cycle, then access held until pready is sampled high at a rising edge
    task automatic xfer(input logic w, input logic [11:0] a, input logic [31:0] d);
        int n;
        @(posedge mclk_i);
        psel   <= 1'b1;
        pwrite <= w;
        paddr  <= a;
        pwdata <= d;
        @(posedge mclk_i);
        penable <= 1'b1;
        n = 0;
        do begin
            @(posedge mclk_i);
            n++;
        end while (pready !== 1'b1 && n < 64);
        tmo = (pready !== 1'b1);
        rd  = prdata;
        err = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
        pwdata  <= ~d; // Released bus must not keep showing the old word
    endtask : xfer
endmodule : srp_host_model

//--- bench/soc_report_and_protection_tb.sv
`timescale 1ns/1ps
`include "srp_regs.svh"
module soc_report_and_protection_tb;
    import srp_pkg::*;
    logic        mclk_i, psel, penable, pwrite, pready, pslverr, irq_o, host_int_o, fast_scale_o;
    logic        scale_pulse_o, therm_en_o, sys_rst_i = 1'b1, tick_i = 1'b0, charging_i = 1'b0;
    logic        discharging_i = 1'b0, meas_vld_i = 1'b0, chg_conn_i = 1'b0, below_por_i = 1'b0, fault_i = 1'b0;
    logic [4:0]  det = 5'h00;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata, seed = 32'h00ED1EC5;
    logic [15:0] true_rm_i = 16'h0800, true_fcc_i = 16'h1000, volt_i = 16'h1000;
    logic [15:0] cell_res_i = 16'h0000, meas_res_i = 16'h0000, sim_res_o, stored_res_o;
    logic [3:0]  load_sel_o;
    logic [1:0]  pmode_o, tc = 2'h0;
    int          error_cnt = 0, check_count = 0;

    srp_top i_srp_top (.mclk_i, .sys_rst_i, .ce_i(1'b1), .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
        .pready, .pslverr, .tick_i, .charging_i, .discharging_i, .relax_i(1'b0), .true_rm_i, .true_fcc_i,
        .volt_i, .cell_res_i, .meas_res_i, .meas_vld_i, .full_term_i(1'b0), .soh_i(8'h64), .ov_det_i(det[0]),
        .uv_det_i(det[1]), .otc_det_i(det[2]), .otd_det_i(det[3]), .isd_det_i(det[4]), .chg_conn_i,
        .below_por_i, .fault_i, .irq_o, .host_int_o, .fast_scale_o, .scale_pulse_o, .load_sel_o,
        .therm_en_o, .sim_res_o, .stored_res_o, .pmode_o);
    srp_host_model i_srp_host_model (.mclk_i, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready,
        .pslverr);

    // Free-running clock
    initial begin
        mclk_i = 1'b0;
        forever #5 mclk_i = ~mclk_i;
    end
    // Update tick every fourth cycle keeps the 30-tick rescale period short
    always @(posedge mclk_i) begin
        tc     <= tc + 2'h1;
        tick_i <= (tc == 2'h3);
    end
    function automatic logic [31:0] xs(input logic [31:0] s);
        logic [31:0] x;
        x = s ^ (s << 13);
        x = x ^ (x >> 17);
        return x ^ (x << 5);
    endfunction : xs
    task automatic complete_run();
        if (error_cnt == 0 && check_count > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask : complete_run
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        check_count++;
        if (seen !== exp) begin
            error_cnt++;
            $display("CHECK FAILED t=%0t seen %h exp %h", $time, seen, exp);
        end
    endtask : chk
    task automatic cyc(input int n);
        repeat (n) @(posedge mclk_i);
    endtask : cyc
    // A bus hang ends the run through the same report
    task automatic bus(input logic w, input logic [11:0] a, input logic [31:0] d);
        i_srp_host_model.xfer(w, a, d);
        if (i_srp_host_model.tmo) begin
            error_cnt++;
            complete_run();
        end
    endtask : bus
    task automatic rdc(input logic [11:0] a, input logic [31:0] exp);
        bus(1'b0, a, 32'h0000_0000);
        chk(i_srp_host_model.rd, exp);
    endtask : rdc
    task automatic fire(input int i);
        det[i] <= 1'b1;
        @(posedge mclk_i);
        det[i] <= 1'b0;
        cyc(3);
    endtask : fire
    task automatic rst();
        sys_rst_i <= 1'b1;
        cyc(10);
        sys_rst_i <= 1'b0;
    endtask : rst
    // Watchdog for the whole run
    initial begin
        cyc(30000);
        error_cnt++;
        complete_run();
    end

    initial begin
        logic [15:0] tr, dn;
        logic [3:0]  ld, fl;
        int          n;
        rst();
        rdc(`SRP_ADDR_CFG, `SRP_CFG_RST);
        rdc(`SRP_ADDR_TERMV, 32'h0064_0BB8);
        rdc(`SRP_ADDR_FSSOC, {24'h00_0000, `SRP_FSSOC_RST});
        rdc(`SRP_ADDR_TDD_PCT, {24'h00_0000, `SRP_TDD_PCT_RST});
        bus(1'b0, 12'h034, 32'h0000_0000);
        chk(i_srp_host_model.err, 32'h0000_0001);
        // Random resistances and capacities; SOC stays far above the fast-scale start
        for (int k = 0; k < 4; k++) begin
            seed = xs(seed);
            tr = {4'h0, seed[11:0]};
            dn = {4'h0, seed[23:12]};
            ld = seed[27:24];
            fl = seed[31:28];
            seed = xs(seed);
            cell_res_i <= {4'h0, seed[11:0]};
            meas_res_i <= tr + {4'h0, seed[23:12]};
            true_rm_i  <= {5'h00, seed[30:20]} + 16'h0800;
            true_fcc_i <= {4'h1, seed[11:0]};
            charging_i <= seed[31];
            discharging_i <= 1'b1;
            bus(1'b1, `SRP_ADDR_RES, {dn, tr});
            bus(1'b1, `SRP_ADDR_CFG, {8'h00, fl, ld, 16'h0000});
            meas_vld_i <= 1'b1;
            @(posedge mclk_i);
            meas_vld_i <= 1'b0;
            cyc(12);
            chk(sim_res_o, cell_res_i + tr + dn);
            chk(stored_res_o, meas_res_i - tr);
            chk(load_sel_o, ld);
            chk(fast_scale_o, 1'b0);
            rdc(`SRP_ADDR_REPORT, {true_fcc_i, true_rm_i});
        end
        // Voltage below the terminate margin while discharging enters fast scaling
        charging_i    <= 1'b0;
        volt_i        <= 16'h0100;
        discharging_i <= 1'b1;
        cyc(12);
        chk(fast_scale_o, 1'b1);
        chk(load_sel_o, fl);
        chk(therm_en_o, 1'b0);
        bus(1'b1, `SRP_ADDR_CFG, {8'h00, fl, ld, 16'h1000});
        cyc(2);
        chk(therm_en_o, 1'b1);
        n = -1;
        for (int c = 0; c < 600; c++) begin
            @(posedge mclk_i);
            if (n >= 0 && tick_i) n++;
            if (scale_pulse_o === 1'b1) begin
                if (n >= 0) break;
                n = 0;
            end
        end
        chk(n, 30);
        // Each of the five detector events sets its interrupt status bit; reading interrupt status clears it
        bus(1'b1, `SRP_ADDR_IRQ_MASK, 32'h0000_007F);
        for (int i = 0; i < 5; i++) begin
            fire(i);
            chk(irq_o, 1'b1);
            chk(host_int_o, 1'b0);
            rdc(`SRP_ADDR_IRQ_STAT, 32'h1 << i);
            cyc(2);
            chk(irq_o, 1'b0);
        end
        bus(1'b1, `SRP_ADDR_IRQ_MASK, 32'h0000_0000);
        fire(0);
        chk(irq_o, 1'b0);
        rdc(`SRP_ADDR_IRQ_STAT, 32'h0000_0001);
        rdc(`SRP_ADDR_IRQ_STAT, 32'h0000_0000);
        bus(1'b1, `SRP_ADDR_IRQ_MASK, 32'h0000_003C);
        bus(1'b1, `SRP_ADDR_CFG, 32'h0000_0600);
        fire(2);
        chk(host_int_o, 1'b0);
        rdc(`SRP_ADDR_IRQ_STAT, 32'h0000_0004);
        bus(1'b1, `SRP_ADDR_CFG, 32'h0000_0200);
        fire(2);
        chk(host_int_o, 1'b1);
        // Peak figure limited by the allowed current, then by the reserve
        bus(1'b0, `SRP_ADDR_IRQ_STAT, 32'h0000_0000);
        bus(1'b1, `SRP_ADDR_IMAX_CFG, 32'h0001_0100);
        bus(1'b1, `SRP_ADDR_RESERVE, {16'h0000, true_rm_i - 16'h0040});
        bus(1'b1, `SRP_ADDR_CFG, 32'h0000_0080);
        cyc(12);
        bus(1'b0, `SRP_ADDR_PEAK, 32'h0000_0000);
        chk(i_srp_host_model.rd[15:0], 16'h0100);
        rdc(`SRP_ADDR_IRQ_STAT, 32'h0000_0040);
        bus(1'b1, `SRP_ADDR_CFG, 32'h0000_0180);
        cyc(12);
        bus(1'b0, `SRP_ADDR_PEAK, 32'h0000_0000);
        chk(i_srp_host_model.rd[15:0], 16'h0040);
        // Holds at the top and bottom of the reported charge state
        bus(1'b1, `SRP_ADDR_CFG, 32'h0000_0060);
        true_rm_i <= true_fcc_i;
        cyc(3);
        bus(1'b0, `SRP_ADDR_PEAK, 32'h0);
        chk(i_srp_host_model.rd[23:16], 8'h63);
        true_rm_i <= 16'h0000;
        volt_i    <= 16'h1000;
        cyc(3);
        bus(1'b0, `SRP_ADDR_PEAK, 32'h0);
        chk(i_srp_host_model.rd[23:16], 8'h01);
        // Charger connect after reset: low-voltage, normal, and blocked by a fault
        for (int m = 0; m < 3; m++) begin
            chg_conn_i  <= 1'b0;
            below_por_i <= (m == 0);
            fault_i     <= (m == 2);
            rst();
            chg_conn_i <= 1'b1;
            cyc(4);
            chk(pmode_o, m == 0 ? SRP_PM_LVC : m == 1 ? SRP_PM_NORM : SRP_PM_SHUT);
        end
        complete_run();
    end
endmodule : soc_report_and_protection_tb
